//--- design/rpc_consts.svh
// constants for the receive payload control block
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH
// ==========================================
// register index map (byte address = 4 * index)
`define RPC_CTL_BASE    7'h00
`define RPC_TRK_BASE    7'h20
`define RPC_SIG_BASE    7'h40
`define RPC_GCFG_IDX    7'h60
`define RPC_STAT_IDX    7'h61
`define RPC_CHAN_LAST   5'h18
// ==========================================
// per-channel control fields
`define RPC_SEL_HI      7
`define RPC_SEL_LO      5
`define RPC_MSB_INV_BIT 4
`define RPC_ODD_INV_BIT 3
`define RPC_EVN_INV_BIT 2
`define RPC_LSB_GAP_BIT 1
`define RPC_GAP_BIT     0
`define RPC_STRK_EN_BIT 4
// ==========================================
// global config fields
`define RPC_GSEL_HI     2
`define RPC_CLKEN_BIT   3
`define RPC_MASTER_BIT  4
`define RPC_GCFG_RST    5'h00
// ==========================================
// bit masks, bit 1 of the channel is the byte msb
`define RPC_MSB_MASK    8'h80
`define RPC_ODD_MASK    8'h2A
`define RPC_EVEN_MASK   8'h55
`define RPC_LSB_MASK    8'h01
`define RPC_FULL_MASK   8'hFF
`define RPC_RESP_OKAY   2'h0
`define RPC_RESP_SLVERR 2'h2
`endif

//--- design/rpc_pkg.sv
// types for the receive payload control block
package rpc_pkg;
    // ==========================================
    // datapath sequencer states
    typedef enum logic [2:0] {
        RPC_S_IDLE = 3'b000,
        RPC_S_CTL  = 3'b001,
        RPC_S_TRK  = 3'b010,
        RPC_S_SIG  = 3'b011,
        RPC_S_OUT  = 3'b100
    } rpc_state_t;
    // ==========================================
    // replacement select codes
    typedef enum logic [2:0] {
        RPC_SEL_NONE  = 3'b000,
        RPC_SEL_TRUNK = 3'b001,
        RPC_SEL_ALAW  = 3'b010,
        RPC_SEL_ULAW  = 3'b011
    } rpc_sel_t;
endpackage

//--- design/rpc_regmem.sv
// per-channel register storage, two registered read ports
`timescale 1ns/100ps
module rpc_regmem (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // bus write port
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata,
    // bus read port
    input  wire logic [6:0] addr_a,
    output logic      [7:0] q_a,
    // datapath read port
    input  wire logic [6:0] addr_b,
    output logic      [7:0] q_b
);
    logic [7:0] mem [0:127]; // whole index space, gaps unused

    // ==========================================
    // storage, cleared to zero by reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 128; i++) begin
                mem[i] <= 8'h00;
            end
            q_a <= 8'h00;
            q_b <= 8'h00;
        end else begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            q_a <= mem[addr_a];
            q_b <= mem[addr_b];
        end
    end
endmodule

//--- design/rpc_dmw_gen.sv
// digital milliwatt sequence generator, a-law and mu-law
`timescale 1ns/100ps
module rpc_dmw_gen (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // control
    input  wire logic       advance,
    input  wire logic       alaw,
    // pattern byte
    output logic      [7:0] code
);
    logic [2:0] phase_r; // one step per frame

    // ==========================================
    // phase counter, steps once per frame
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_r <= 3'h0;
        end else if (advance) begin
            phase_r <= phase_r + 3'h1;
        end
    end

    // ==========================================
    // eight-step tone tables
    always_comb begin
        case (phase_r)
            3'h0, 3'h3: code = alaw ? 8'h34 : 8'h1E;
            3'h1, 3'h2: code = alaw ? 8'h21 : 8'h0B;
            3'h4, 3'h7: code = alaw ? 8'hB4 : 8'h9E;
            default:    code = alaw ? 8'hA1 : 8'h8B;
        endcase
    end
endmodule

//--- design/rpc_payload_ctl.sv
// receive payload control: per-channel replace, invert, gap
`timescale 1ns/100ps
`include "rpc_consts.svh"

// Functional notes
// - control registers at indexes 01H..18H
// - data trunk registers at 21H..38H
// - signaling trunk registers at 41H..58H
// - per-channel select only when global is 000
// - 001 substitutes data trunk, 000 passes
// - 010 a-law, 011 mu-law milliwatt
// - even invert flips bits 2,4,6,8
// - odd invert flips bits 3,5,7
// - sign invert flips bit 1
// - inversion controls combine as union
// - gapping needs clock master and enable
// - 56k gap suppresses bit 8 only
// - full gap suppresses whole channel
// - data trunk register holds eight bits
// - signaling trunk enable substitutes ABCD
module rpc_payload_ctl (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    // axi4-lite write address and data
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [8:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    // axi4-lite write response
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic      [1:0]  S_AXI_BRESP,
    // axi4-lite read
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [8:0]  S_AXI_ARADDR,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic      [31:0] S_AXI_RDATA,
    output logic      [1:0]  S_AXI_RRESP,
    // received channel byte stream
    input  wire logic        RX_VALID,
    input  wire logic [4:0]  RX_CHAN,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic [3:0]  RX_SIG,
    // conditioned stream toward backplane
    output logic             PL_VALID,
    output logic      [4:0]  PL_CHAN,
    output logic      [7:0]  PL_DATA,
    output logic      [3:0]  PL_SIG,
    output logic      [7:0]  PL_GAP_MASK
);
    // ==========================================
    // helper functions
    function automatic logic [6:0] bank_idx(input logic [6:0] base, input logic [4:0] ch);
        bank_idx = base + {2'h0, ch};
    endfunction

    function automatic logic in_bank(input logic [6:0] idx, input logic [6:0] base);
        in_bank = (idx > base) && (idx <= bank_idx(base, `RPC_CHAN_LAST));
    endfunction

    function automatic logic is_mapped(input logic [6:0] idx);
        is_mapped = in_bank(idx, `RPC_CTL_BASE) || in_bank(idx, `RPC_TRK_BASE)
            || in_bank(idx, `RPC_SIG_BASE)
            || (idx == `RPC_GCFG_IDX) || (idx == `RPC_STAT_IDX);
    endfunction

    // ==========================================
    // bus-side state
    logic        awready_r;      // address slot free
    logic        wready_r;       // data slot free
    logic        aw_full_r;      // address held
    logic        w_full_r;       // data held
    logic [6:0]  aw_idx_r;       // held write index
    logic [7:0]  wbyte_r;        // held write byte
    logic        wstrb0_r;       // low lane enable
    logic        bvalid_r;       // write answer pending
    logic [1:0]  bresp_r;        // write answer code
    logic        arready_r;      // read slot free
    logic [6:0]  ar_idx_r;       // read index
    logic        rd_pend_r;      // memory read in flight
    logic        rvalid_r;       // read answer pending
    logic [31:0] rdata_r;        // read data
    logic [1:0]  rresp_r;        // read answer code
    logic [4:0]  gcfg_r;         // global_replace_sel, clock enable, master
    logic [4:0]  last_chan_r;    // last channel conditioned

    // ==========================================
    // datapath state
    rpc_pkg::rpc_state_t st_r;
    rpc_pkg::rpc_state_t st_nxt;
    logic [4:0]  chan_r;         // channel in work
    logic [7:0]  byte_r;         // received byte
    logic [3:0]  rsig_r;         // received signaling
    logic [7:0]  ctl_r;          // channel control copy
    logic [7:0]  trk_r;          // data_trunk_code copy
    logic        pl_valid_r;
    logic [4:0]  pl_chan_r;
    logic [7:0]  pl_data_r;
    logic [3:0]  pl_sig_r;
    logic [7:0]  pl_gap_r;

    // ==========================================
    // decode wires
    wire logic       aw_take   = S_AXI_AWVALID && awready_r;
    wire logic       w_take    = S_AXI_WVALID && wready_r;
    wire logic       commit    = aw_full_r && w_full_r && !bvalid_r;
    wire logic       aw_map    = is_mapped(aw_idx_r);
    wire logic       aw_gcfg   = aw_idx_r == `RPC_GCFG_IDX;
    wire logic       aw_stat   = aw_idx_r == `RPC_STAT_IDX;
    // status is read only, so writes there do not reach storage
    wire logic       mem_we    = commit && aw_map && wstrb0_r && !aw_gcfg && !aw_stat;
    wire logic       ar_take   = S_AXI_ARVALID && arready_r;
    wire logic [6:0] ar_idx_in = S_AXI_ARADDR[8:2];
    wire logic       b_done    = bvalid_r && S_AXI_BREADY;
    wire logic       r_done    = rvalid_r && S_AXI_RREADY;
    wire logic [7:0] q_a;
    wire logic [7:0] q_b;
    logic      [6:0] addr_b;     // datapath read index
    logic      [31:0] rd_mux;    // read data select
    logic      [1:0]  rd_resp;   // read code select

    // ==========================================
    // register storage
    rpc_regmem u_mem (
        .clk    (CLK_SYS),
        .reset  (RESET),
        .we     (mem_we),
        .waddr  (aw_idx_r),
        .wdata  (wbyte_r),
        .addr_a (ar_idx_in),
        .q_a    (q_a),
        .addr_b (addr_b),
        .q_b    (q_b)
    );

    // ==========================================
    // write address and data capture, either order
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_idx_r  <= 7'h00;
            wbyte_r   <= 8'h00;
            wstrb0_r  <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
                aw_idx_r  <= S_AXI_AWADDR[8:2];
            end else if (commit) begin
                aw_full_r <= 1'b0;
            end
            if (w_take) begin
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
                wbyte_r  <= S_AXI_WDATA[7:0];
                wstrb0_r <= S_AXI_WSTRB[0];
            end else if (commit) begin
                w_full_r <= 1'b0;
            end
            // slots reopen only once the answer is taken
            if (b_done) begin
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // ==========================================
    // write answer and global config register
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `RPC_RESP_OKAY;
            gcfg_r   <= `RPC_GCFG_RST;
        end else begin
            if (commit) begin
                bvalid_r <= 1'b1;
                bresp_r  <= aw_map ? `RPC_RESP_OKAY : `RPC_RESP_SLVERR;
                if (aw_gcfg && wstrb0_r) begin
                    gcfg_r <= wbyte_r[4:0];
                end
            end else if (b_done) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ==========================================
    // read data select
    always_comb begin
        rd_mux  = 32'h0000_0000;
        rd_resp = `RPC_RESP_OKAY;
        if (ar_idx_r == `RPC_GCFG_IDX) begin
            rd_mux = {27'h0, gcfg_r};
        end else if (ar_idx_r == `RPC_STAT_IDX) begin
            rd_mux = {26'h0, (st_r != rpc_pkg::RPC_S_IDLE), last_chan_r};
        end else if (is_mapped(ar_idx_r)) begin
            rd_mux = {24'h0, q_a};
        end else begin
            rd_resp = `RPC_RESP_SLVERR;
        end
    end

    // ==========================================
    // read channel, answer one cycle after the address
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            arready_r <= 1'b1;
            ar_idx_r  <= 7'h00;
            rd_pend_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `RPC_RESP_OKAY;
        end else begin
            if (ar_take) begin
                arready_r <= 1'b0;
                ar_idx_r  <= ar_idx_in;
                rd_pend_r <= 1'b1;
            end else if (rd_pend_r) begin
                rd_pend_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_mux;
                rresp_r   <= rd_resp;
            end else if (r_done) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ==========================================
    // datapath decode
    wire logic [2:0] gsel    = gcfg_r[`RPC_GSEL_HI:0];
    wire logic [2:0] eff_sel = (gsel != 3'b000) ? gsel : ctl_r[`RPC_SEL_HI:`RPC_SEL_LO];
    wire logic       rx_ok   = (RX_CHAN != 5'h00) && (RX_CHAN <= `RPC_CHAN_LAST);
    wire logic       accept  = (st_r == rpc_pkg::RPC_S_IDLE) && RX_VALID && rx_ok;
    wire logic       in_out  = st_r == rpc_pkg::RPC_S_OUT;
    wire logic       gate    = gcfg_r[`RPC_MASTER_BIT] && gcfg_r[`RPC_CLKEN_BIT];
    wire logic       frame_end = in_out && (chan_r == `RPC_CHAN_LAST);
    wire logic [7:0] dmw_code;
    logic      [7:0] rep_data;   // byte after replacement
    logic      [7:0] inv_mask;   // union of inversions
    logic      [7:0] gap_mask;   // suppressed bit clocks

    rpc_dmw_gen u_dmw (
        .clk     (CLK_SYS),
        .reset   (RESET),
        .advance (frame_end),
        .alaw    (eff_sel == rpc_pkg::RPC_SEL_ALAW),
        .code    (dmw_code)
    );

    // ==========================================
    // replacement, inversion and gapping
    always_comb begin
        case (eff_sel)
            rpc_pkg::RPC_SEL_TRUNK: rep_data = trk_r;
            rpc_pkg::RPC_SEL_ALAW:  rep_data = dmw_code;
            rpc_pkg::RPC_SEL_ULAW:  rep_data = dmw_code;
            default:                rep_data = byte_r;
        endcase
        inv_mask = 8'h00;
        if (ctl_r[`RPC_MSB_INV_BIT]) begin
            inv_mask = inv_mask | `RPC_MSB_MASK;
        end
        if (ctl_r[`RPC_ODD_INV_BIT]) begin
            inv_mask = inv_mask | `RPC_ODD_MASK;
        end
        if (ctl_r[`RPC_EVN_INV_BIT]) begin
            inv_mask = inv_mask | `RPC_EVEN_MASK;
        end
        gap_mask = 8'h00;
        if (gate && ctl_r[`RPC_GAP_BIT]) begin
            gap_mask = `RPC_FULL_MASK;
        end else if (gate && ctl_r[`RPC_LSB_GAP_BIT]) begin
            gap_mask = `RPC_LSB_MASK;
        end
    end

    // ==========================================
    // sequencer: three reads, then one output byte
    always_comb begin
        st_nxt = st_r;
        addr_b = bank_idx(`RPC_CTL_BASE, chan_r);
        case (st_r)
            rpc_pkg::RPC_S_IDLE: begin
                if (accept) begin
                    st_nxt = rpc_pkg::RPC_S_CTL;
                end
            end
            rpc_pkg::RPC_S_CTL: begin
                st_nxt = rpc_pkg::RPC_S_TRK;
            end
            rpc_pkg::RPC_S_TRK: begin
                addr_b = bank_idx(`RPC_TRK_BASE, chan_r);
                st_nxt = rpc_pkg::RPC_S_SIG;
            end
            rpc_pkg::RPC_S_SIG: begin
                addr_b = bank_idx(`RPC_SIG_BASE, chan_r);
                st_nxt = rpc_pkg::RPC_S_OUT;
            end
            default: begin
                st_nxt = rpc_pkg::RPC_S_IDLE;
            end
        endcase
    end

    // ==========================================
    // sequencer registers and operand capture
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            st_r   <= rpc_pkg::RPC_S_IDLE;
            chan_r <= 5'h00;
            byte_r <= 8'h00;
            rsig_r <= 4'h0;
            ctl_r  <= 8'h00;
            trk_r  <= 8'h00;
        end else begin
            st_r <= st_nxt;
            // new bytes are dropped while a channel is in work
            if (accept) begin
                chan_r <= RX_CHAN;
                byte_r <= RX_DATA;
                rsig_r <= RX_SIG;
            end
            if (st_r == rpc_pkg::RPC_S_TRK) begin
                ctl_r <= q_b;
            end
            if (st_r == rpc_pkg::RPC_S_SIG) begin
                trk_r <= q_b;
            end
        end
    end

    // ==========================================
    // backplane outputs
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            pl_valid_r  <= 1'b0;
            pl_chan_r   <= 5'h00;
            pl_data_r   <= 8'h00;
            pl_sig_r    <= 4'h0;
            pl_gap_r    <= 8'h00;
            last_chan_r <= 5'h00;
        end else begin
            pl_valid_r <= in_out;
            if (in_out) begin
                pl_chan_r   <= chan_r;
                pl_data_r   <= rep_data ^ inv_mask;
                pl_sig_r    <= q_b[`RPC_STRK_EN_BIT] ? q_b[3:0] : rsig_r;
                pl_gap_r    <= gap_mask;
                last_chan_r <= chan_r;
            end
        end
    end

    // ==========================================
    // output drive
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY  = wready_r;
    assign S_AXI_BVALID  = bvalid_r;
    assign S_AXI_BRESP   = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID  = rvalid_r;
    assign S_AXI_RDATA   = rdata_r;
    assign S_AXI_RRESP   = rresp_r;
    assign PL_VALID      = pl_valid_r;
    assign PL_CHAN       = pl_chan_r;
    assign PL_DATA       = pl_data_r;
    assign PL_SIG        = pl_sig_r;
    assign PL_GAP_MASK   = pl_gap_r;

    // ==========================================
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    sequence seq_walk;
        st_r == rpc_pkg::RPC_S_CTL ##1 st_r == rpc_pkg::RPC_S_TRK
            ##1 st_r == rpc_pkg::RPC_S_SIG ##1 st_r == rpc_pkg::RPC_S_OUT;
    endsequence

    a_walk_latency: assert property (accept |=> seq_walk ##1 pl_valid_r)
        else $error("channel byte not delivered five cycles after accept");
    // global trunk select must win whatever the channel's own select holds
    a_global_wins: assert property (in_out && gsel == 3'b001
            |=> pl_data_r == ($past(trk_r) ^ $past(inv_mask)))
        else $error("global select did not govern replacement");
    a_trunk_sub: assert property (in_out && eff_sel == 3'b001 |=> pl_data_r == ($past(trk_r) ^ $past(inv_mask)))
        else $error("trunk code not substituted");
    a_pass_data: assert property (in_out && eff_sel[2] |=> pl_data_r == ($past(byte_r) ^ $past(inv_mask)))
        else $error("reserved select corrupted data");
    a_all_invert: assert property (in_out && ctl_r[4:2] == 3'b111 && eff_sel == 3'b000
            |=> pl_data_r == ~$past(byte_r))
        else $error("full inversion failed");
    a_odd_invert: assert property (in_out && ctl_r[4:2] == 3'b010 && eff_sel == 3'b000
            |=> (pl_data_r ^ $past(byte_r)) == 8'h2A)
        else $error("odd inversion wrong");
    a_gap_full: assert property (in_out && gate && ctl_r[0] |=> pl_gap_r == 8'hFF)
        else $error("full channel gap missing");
    a_gap_lsb: assert property (in_out && gate && ctl_r[1:0] == 2'b10 |=> pl_gap_r == 8'h01)
        else $error("bit 8 gap wrong");
    a_gap_off: assert property (in_out && !gate |=> pl_gap_r == 8'h00)
        else $error("gap applied outside clock master mode");
    a_sig_trunk: assert property (in_out && q_b[4] |=> pl_sig_r == $past(q_b[3:0]))
        else $error("signaling trunk code not applied");
    a_bus_answer: assert property (commit |=> bvalid_r && bresp_r == $past(aw_map ? 2'h0 : 2'h2))
        else $error("write answer missing");
endmodule

//--- test/rpc_bp_model.sv
// backplane receiver model: takes each conditioned byte off the stream
`timescale 1ns/100ps
module rpc_bp_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // conditioned stream from the block
    input  wire logic        pl_valid,
    input  wire logic [4:0]  pl_chan,
    input  wire logic [7:0]  pl_data,
    input  wire logic [3:0]  pl_sig,
    input  wire logic [7:0]  pl_gap_mask,
    // last byte taken and running count
    output logic      [15:0] got_n,
    output logic      [4:0]  got_c,
    output logic      [7:0]  got_d,
    output logic      [3:0]  got_s,
    output logic      [7:0]  got_g
);
    // ==========================================
    // capture on every cycle that valid is high, so a held bus is taken once per cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            got_n <= 16'h0000;
            got_c <= 5'h00;
            got_d <= 8'h00;
            got_s <= 4'h0;
            got_g <= 8'h00;
        end else if (pl_valid) begin
            got_n <= got_n + 16'h0001;
            got_c <= pl_chan;
            got_d <= pl_data;
            got_s <= pl_sig;
            got_g <= pl_gap_mask;
        end
    end
endmodule

//--- test/test_rx_payload_channel_control.sv
// self-checking bench for the receive payload control block
`timescale 1ns/100ps
module test_rx_payload_channel_control;
    // ==========================================
    // stimulus and observed signals
    logic        clk_sys = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, rx_valid = 1'b0;
    logic [8:0]  awaddr = 9'h000, araddr = 9'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  wstrb = 4'h0, rx_sig = 4'h0;
    logic [4:0]  rx_chan = 5'h00;
    logic [7:0]  rx_data = 8'h00;
    logic        awready, wready, bvalid, arready, rvalid, pl_valid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [4:0]  pl_chan, got_c;
    logic [7:0]  pl_data, pl_gap, got_d, got_g;
    logic [3:0]  pl_sig, got_s;
    logic [15:0] got_n;
    int          miscompares = 0, checks = 0, cyc = 0;
    // rows: control, trunk, data in, signaling reg, expected data, expected gap mask
    logic [47:0] rows [10] = '{48'h0000A500A500, 48'h203CA5003C00, 48'h040000005500, 48'h080000002A00,
                               48'h100000008000, 48'h1C000019FF00, 48'h020011001101, 48'h0300110011FF,
                               48'h80005A005A00, 48'h243C00006900};
    always #25 clk_sys = ~clk_sys;
    rpc_payload_ctl DUT (.CLK_SYS(clk_sys), .RESET(reset), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .RX_VALID(rx_valid),
        .RX_CHAN(rx_chan), .RX_DATA(rx_data), .RX_SIG(rx_sig), .PL_VALID(pl_valid), .PL_CHAN(pl_chan),
        .PL_DATA(pl_data), .PL_SIG(pl_sig), .PL_GAP_MASK(pl_gap));
    rpc_bp_model u_bp (.clk(clk_sys), .reset(reset), .pl_valid(pl_valid), .pl_chan(pl_chan),
        .pl_data(pl_data), .pl_sig(pl_sig), .pl_gap_mask(pl_gap), .got_n(got_n), .got_c(got_c),
        .got_d(got_d), .got_s(got_s), .got_g(got_g));
    // ==========================================
    // verdict and hang guard
    task automatic tally_and_finish;
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ==========================================
    // bus write: address and data released separately, response awaited
    task automatic wr(input logic [8:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clk_sys);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= {24'h000000, d}; wstrb <= 4'hF; bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
            if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // one byte in, wait for the model to take its conditioned copy
    task automatic snd(input logic [4:0] c, input logic [7:0] d, input logic [7:0] ed, input logic [7:0] eg);
        logic [15:0] n0;
        n0 = got_n;
        @(posedge clk_sys);
        rx_valid <= 1'b1; rx_chan <= c; rx_data <= d; rx_sig <= 4'h6;
        @(posedge clk_sys);
        rx_valid <= 1'b0; rx_data <= ~d; rx_sig <= 4'h9;
        while (got_n == n0) @(posedge clk_sys);
        chk({24'h0, got_d}, {24'h0, ed});
        chk({24'h0, got_g}, {24'h0, eg});
        chk({27'h0, got_c}, {27'h0, c});
    endtask
    // ==========================================
    // main sequence
    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        logic [4:0]  ch;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd(9'h004, d, r); chk(d, 32'h0);
        rd(9'h0E0, d, r); chk(d, 32'h0);
        rd(9'h064, d, r); chk({30'h0, r}, 32'h2);
        wr(9'h064, 8'h55, r); chk({30'h0, r}, 32'h2);
        wr(9'h180, 8'h18, r);
        for (int i = 0; i < 10; i++) begin
            ch = 5'(i + 1);
            wr({2'b00, ch, 2'b00}, rows[i][47:40], r);
            wr({2'b01, ch, 2'b00}, rows[i][39:32], r);
            wr({2'b10, ch, 2'b00}, rows[i][23:16], r);
            snd(ch, rows[i][31:24], rows[i][15:8], rows[i][7:0]);
            chk({28'h0, got_s}, {28'h0, rows[i][20] ? rows[i][19:16] : 4'h6});
        end
        rd(9'h088, d, r); chk(d, 32'h3C);
        rd(9'h028, d, r); chk(d, 32'h24);
        rd(9'h118, d, r); chk(d, 32'h19);
        wr(9'h180, 8'h08, r);
        snd(5'h08, 8'h11, 8'h11, 8'h00);
        wr(9'h180, 8'h10, r);
        snd(5'h07, 8'h11, 8'h11, 8'h00);
        wr(9'h180, 8'h01, r);
        snd(5'h03, 8'hA5, 8'h55, 8'h00);
        wr(9'h180, 8'h00, r);
        snd(5'h03, 8'hA5, 8'hF0, 8'h00);
        wr(9'h02C, 8'h40, r);
        wr(9'h060, 8'h60, r);
        snd(5'h0B, 8'h00, 8'h34, 8'h00);
        snd(5'h18, 8'h00, 8'h1E, 8'h00);
        snd(5'h0B, 8'h00, 8'h21, 8'h00);
        rd(9'h184, d, r);
        chk(d, 32'h0000000B);
        // mid-run reset: storage, config and outputs must all clear
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        chk({24'h0, pl_data}, 32'h0);
        rd(9'h028, d, r);
        chk(d, 32'h0);
        rd(9'h180, d, r);
        chk(d, 32'h0);
        rd(9'h184, d, r);
        chk(d, 32'h0);
        tally_and_finish;
    end
endmodule
